// ### rtl/eth_tx_desc_ctrl.v
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "eth_tx_desc_map.vh"

module eth_tx_desc_ctrl (
   // Clock and reset
   input wire clk_in,
   input wire sys_rst_in,
   // Avalon-MM slave
   input wire [4:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output reg [31:0] avs_readdata_out,
   output reg avs_waitrequest_out,
   output reg irq_out,
   // Descriptor fetch
   input wire desc_valid_in,
   output reg desc_ready_out,
   input wire [31:0] desc_addr_in,
   input wire [31:0] desc_word0_in,
   input wire [31:0] desc_word1_in,
   input wire [31:0] desc_word2_in,
   // Decoded controls
   output reg ctl_valid_out,
   output reg ctl_first_out,
   output reg ctl_last_out,
   output reg ctl_ts_en_out,
   output reg [1:0] ctl_csum_mode_out,
   output reg [12:0] ctl_buf1_size_out,
   output reg [12:0] ctl_buf2_size_out,
   output reg [31:0] next_desc_addr_out,
   // MAC frame end: pad and CRC plan
   input wire mac_frame_end_in,
   input wire [13:0] mac_frame_len_in,
   output reg mac_plan_valid_out,
   output reg [5:0] mac_pad_bytes_out,
   output reg mac_append_crc_out,
   // IP header seen by the transmitter
   input wire hdr_valid_in,
   input wire [15:0] hdr_eth_type_in,
   input wire [7:0] hdr_ver_ihl_in,
   input wire [7:0] hdr_bytes_in,
   // Timestamp and completion
   input wire ts_valid_in,
   input wire [63:0] ts_value_in,
   input wire mac_tx_done_in,
   // Status write-back
   output reg wb_valid_out,
   output reg [31:0] wb_addr_out,
   output reg [31:0] wb_word0_out,
   output reg [31:0] wb_word2_out,
   output reg [31:0] wb_word3_out
);

   // ==========================================================
   // States
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_FRAME = 3'b010;
   localparam [2:0] ST_WAIT = 3'b100;

   reg [2:0] state_r;
   reg enable_r;
   reg [31:0] ring_base_r;
   reg [3:0] irq_status_r;
   reg [3:0] irq_mask_r;
   reg [31:0] frame_count_r;
   reg supp_crc_r;
   reg supp_pad_r;
   reg ts_en_r;
   reg [1:0] csum_r;
   reg ts_capt_r;
   reg [63:0] ts_r;
   reg hdr_err_r;
   reg [31:0] last_word0_r;
   reg [31:0] last_addr_r;
   wire hdr_err;
   wire [3:0] irq_evt;

   // ==========================================================
   // Header checker
   ip_hdr_check u_hdr_check (
      .eth_type_in(hdr_eth_type_in),
      .ver_ihl_in(hdr_ver_ihl_in),
      .hdr_bytes_in(hdr_bytes_in),
      .hdr_err_out(hdr_err)
   );

   // ==========================================================
   // Bus decode
   wire [2:0] reg_idx = avs_address_in[4:2];
   wire bus_req = avs_read_in | avs_write_in;
   // Access completes on the edge where waitrequest is seen low
   wire bus_done = bus_req & ~avs_waitrequest_out;
   wire wr_done = avs_write_in & bus_done;
   wire rd_done = avs_read_in & bus_done;
   wire be0 = avs_byteenable_in[0];

   // Byte-lane merge for 32-bit registers
   function [31:0] lane_merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] be;
      integer i;
      begin
         lane_merge = old_val;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i])
               lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
   endfunction

   // ==========================================================
   // Descriptor decode
   wire desc_take = desc_valid_in & desc_ready_out;
   wire d_first = desc_word0_in[`W0_FIRST];
   wire d_last = desc_word0_in[`W0_LAST];
   wire d_ring_end = desc_word0_in[`W0_RING_END];
   wire d_chained = desc_word0_in[`W0_CHAINED];
   wire [1:0] d_csum = desc_word0_in[`W0_CSUM_HI:`W0_CSUM_LO];

   // Frame controls: latched from first segment, held otherwise
   wire f_ts_en = d_first ? desc_word0_in[`W0_TS_EN]
                          : ts_en_r;
   wire [1:0] f_csum = d_first ? d_csum : csum_r;

   // Ring end outranks chaining; neither means the next slot
   reg [31:0] next_addr;
   always @* begin
      if (d_ring_end)
         next_addr = ring_base_r;
      else if (d_chained)
         next_addr = desc_word2_in;
      else
         next_addr = desc_addr_in + `DESC_STRIDE;
   end

   // ==========================================================
   // Pad and CRC plan at frame end
   wire [13:0] min_data = `MIN_FRAME_BYTES - `CRC_BYTES;
   wire is_short = (mac_frame_len_in < min_data);
   wire [13:0] pad_gap = min_data - mac_frame_len_in;

   // ==========================================================
   // Bus slave: one wait cycle per access
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         if (bus_req & avs_waitrequest_out)
            avs_waitrequest_out <= 1'b0;
         else
            avs_waitrequest_out <= 1'b1;
         // Read data stands while waitrequest is low
         if (avs_read_in & avs_waitrequest_out) begin
            if (reg_idx == `REG_CTRL)
               avs_readdata_out <= {31'h0000_0000, enable_r};
            else if (reg_idx == `REG_RING_BASE)
               avs_readdata_out <= ring_base_r;
            else if (reg_idx == `REG_IRQ_STATUS)
               avs_readdata_out <= {28'h000_0000, irq_status_r | irq_evt};
            else if (reg_idx == `REG_IRQ_MASK)
               avs_readdata_out <= {28'h000_0000, irq_mask_r};
            else if (reg_idx == `REG_FRAME_STATE)
               avs_readdata_out <= {24'h00_0000, hdr_err_r,
                  ts_capt_r, csum_r, ts_en_r, supp_pad_r,
                  supp_crc_r, ~state_r[0]};
            else if (reg_idx == `REG_FRAME_COUNT)
               avs_readdata_out <= frame_count_r;
            else
               avs_readdata_out <= 32'h0000_0000;
         end
      end
   end

   // Control registers written by software
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         enable_r <= `CTRL_RST;
         ring_base_r <= `RING_BASE_RST;
         irq_mask_r <= `IRQ_MASK_RST;
      end else if (wr_done) begin
         if (reg_idx == `REG_CTRL) begin
            if (be0)
               enable_r <= avs_writedata_in[0];
         end else if (reg_idx == `REG_RING_BASE) begin
            ring_base_r <= lane_merge(ring_base_r,
               avs_writedata_in, avs_byteenable_in);
         end else if (reg_idx == `REG_IRQ_MASK) begin
            if (be0)
               irq_mask_r <= avs_writedata_in[3:0];
         end
      end
   end

   // ==========================================================
   // Interrupt status: read clears, a new event wins
   assign irq_evt[`IRQ_TS] = ts_valid_in & ts_en_r & ~state_r[0];
   assign irq_evt[`IRQ_HDR_ERR] = hdr_valid_in & hdr_err;
   assign irq_evt[`IRQ_WRAP] = desc_take & d_ring_end;
   assign irq_evt[`IRQ_DONE] = mac_tx_done_in & state_r[2];
   wire rd_status = rd_done & (reg_idx == `REG_IRQ_STATUS);

   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_status_r <= 4'h0;
         irq_out <= 1'b0;
      end else begin
         if (rd_status)
            irq_status_r <= irq_evt;
         else
            irq_status_r <= irq_status_r | irq_evt;
         irq_out <= |((rd_status ? irq_evt
            : (irq_status_r | irq_evt)) & irq_mask_r);
      end
   end

   // ==========================================================
   // Frame sequencing
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_r <= ST_IDLE;
         desc_ready_out <= 1'b0;
         supp_crc_r <= 1'b0;
         supp_pad_r <= 1'b0;
         ts_en_r <= 1'b0;
         csum_r <= `CSUM_OFF;
         last_word0_r <= 32'h0000_0000;
         last_addr_r <= 32'h0000_0000;
         frame_count_r <= 32'h0000_0000;
      end else begin
         // Descriptors are refused while a write-back is pending
         desc_ready_out <= enable_r & ~state_r[2]
            & ~(desc_take & d_last);
         if (desc_take & d_first) begin
            supp_crc_r <= desc_word0_in[`W0_SUPP_CRC];
            supp_pad_r <= desc_word0_in[`W0_SUPP_PAD];
            ts_en_r <= desc_word0_in[`W0_TS_EN];
            csum_r <= d_csum;
         end
         case (state_r)
            ST_IDLE: begin
               if (desc_take)
                  state_r <= d_last ? ST_WAIT : ST_FRAME;
               if (desc_take & d_last) begin
                  last_word0_r <= desc_word0_in;
                  last_addr_r <= desc_addr_in;
               end
            end
            ST_FRAME: begin
               if (desc_take & d_last) begin
                  state_r <= ST_WAIT;
                  last_word0_r <= desc_word0_in;
                  last_addr_r <= desc_addr_in;
               end
            end
            ST_WAIT: begin
               if (mac_tx_done_in) begin
                  state_r <= ST_IDLE;
                  frame_count_r <= frame_count_r + 32'h0000_0001;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Decoded control outputs
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctl_valid_out <= 1'b0;
         ctl_first_out <= 1'b0;
         ctl_last_out <= 1'b0;
         ctl_ts_en_out <= 1'b0;
         ctl_csum_mode_out <= `CSUM_OFF;
         ctl_buf1_size_out <= 13'h0000;
         ctl_buf2_size_out <= 13'h0000;
         next_desc_addr_out <= 32'h0000_0000;
      end else begin
         ctl_valid_out <= desc_take;
         if (desc_take) begin
            ctl_first_out <= d_first;
            ctl_last_out <= d_last;
            ctl_ts_en_out <= f_ts_en;
            ctl_csum_mode_out <= f_csum;
            ctl_buf1_size_out <=
               desc_word1_in[`W1_BUF1_HI:`W1_BUF1_LO];
            // Second size is meaningless when word2 is a pointer
            if (d_chained & ~d_ring_end)
               ctl_buf2_size_out <= 13'h0000;
            else
               ctl_buf2_size_out <=
                  desc_word1_in[`W1_BUF2_HI:`W1_BUF2_LO];
            next_desc_addr_out <= next_addr;
         end
      end
   end

   // ==========================================================
   // Pad and CRC plan; short padded frames always get CRC
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mac_plan_valid_out <= 1'b0;
         mac_pad_bytes_out <= 6'h00;
         mac_append_crc_out <= 1'b0;
      end else begin
         mac_plan_valid_out <= mac_frame_end_in;
         if (mac_frame_end_in) begin
            if (is_short & ~supp_pad_r) begin
               mac_pad_bytes_out <= pad_gap[5:0];
               mac_append_crc_out <= 1'b1;
            end else begin
               mac_pad_bytes_out <= 6'h00;
               mac_append_crc_out <= ~supp_crc_r;
            end
         end
      end
   end

   // ==========================================================
   // Per-frame status capture, cleared when a frame starts
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ts_capt_r <= 1'b0;
         ts_r <= 64'h0000_0000_0000_0000;
         hdr_err_r <= 1'b0;
      end else if (desc_take & d_first) begin
         ts_capt_r <= 1'b0;
         hdr_err_r <= 1'b0;
      end else begin
         // Only frames that asked for it capture the time
         if (irq_evt[`IRQ_TS]) begin
            ts_capt_r <= 1'b1;
            ts_r <= ts_value_in;
         end
         if (hdr_valid_in & hdr_err)
            hdr_err_r <= 1'b1;
      end
   end

   // ==========================================================
   // Write-back to the last-segment descriptor
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wb_valid_out <= 1'b0;
         wb_addr_out <= 32'h0000_0000;
         wb_word0_out <= 32'h0000_0000;
         wb_word2_out <= 32'h0000_0000;
         wb_word3_out <= 32'h0000_0000;
      end else begin
         wb_valid_out <= irq_evt[`IRQ_DONE];
         if (irq_evt[`IRQ_DONE]) begin
            wb_addr_out <= last_addr_r;
            wb_word0_out <= last_word0_r;
            wb_word0_out[`W0_TS_CAPT] <= ts_capt_r;
            wb_word0_out[`W0_IP_HDR_ERR] <= hdr_err_r;
            // Stale words are zeroed when nothing was captured
            wb_word2_out <= ts_capt_r ? ts_r[31:0]
                                      : 32'h0000_0000;
            wb_word3_out <= ts_capt_r ? ts_r[63:32]
                                      : 32'h0000_0000;
         end
      end
   end

endmodule

// ### rtl/eth_tx_desc_map.vh
`ifndef ETH_TX_DESC_MAP_VH
`define ETH_TX_DESC_MAP_VH

// ==========================================================
// Descriptor word 0 and word 1 fields
`define W0_IP_HDR_ERR 5'd16
`define W0_TS_CAPT 5'd17
`define W0_CHAINED 5'd20
`define W0_RING_END 5'd21
`define W0_CSUM_LO 5'd22
`define W0_CSUM_HI 5'd23
`define W0_TS_EN 5'd25
`define W0_SUPP_PAD 5'd26
`define W0_SUPP_CRC 5'd27
`define W0_FIRST 5'd28
`define W0_LAST 5'd29
`define W1_BUF1_LO 5'd0
`define W1_BUF1_HI 5'd12
`define W1_BUF2_LO 5'd16
`define W1_BUF2_HI 5'd28
`define DESC_STRIDE 32'h0000_0010

// ==========================================================
// Frame and header constants
`define MIN_FRAME_BYTES 14'h0040
`define CRC_BYTES 14'h0004
`define IPV6_HDR_BYTES 8'h28
`define IPV4_MIN_IHL 4'h5
`define ETYPE_IPV4 16'h0800
`define ETYPE_IPV6 16'h86dd
`define CSUM_OFF 2'h0
`define CSUM_IP_HDR 2'h1
`define CSUM_NO_PSEUDO 2'h2
`define CSUM_FULL 2'h3

// ==========================================================
// Register word indices, reset values and interrupt bit positions
`define REG_CTRL 3'h0
`define REG_RING_BASE 3'h1
`define REG_IRQ_STATUS 3'h2
`define REG_IRQ_MASK 3'h3
`define REG_FRAME_STATE 3'h4
`define REG_FRAME_COUNT 3'h5
`define CTRL_RST 1'h0
`define RING_BASE_RST 32'h0000_0000
`define IRQ_MASK_RST 4'h0
`define IRQ_TS 2'd0
`define IRQ_HDR_ERR 2'd1
`define IRQ_WRAP 2'd2
`define IRQ_DONE 2'd3

`endif

// ### rtl/ip_hdr_check.v
`timescale 1ns/1ps
`include "eth_tx_desc_map.vh"

module ip_hdr_check (
   // Header fields seen by the transmitter
   input wire [15:0] eth_type_in,
   input wire [7:0] ver_ihl_in,
   input wire [7:0] hdr_bytes_in,
   // Verdict
   output reg hdr_err_out
);

   // ==========================================================
   // Header consistency check
   wire is_v4 = (eth_type_in == `ETYPE_IPV4);
   wire is_v6 = (eth_type_in == `ETYPE_IPV6);
   wire [3:0] version = ver_ihl_in[7:4];
   wire [3:0] ihl = ver_ihl_in[3:0];
   wire [7:0] ihl_bytes = {2'b00, ihl, 2'b00};

   // Non-IP frames are never flagged
   always @* begin
      hdr_err_out = 1'b0;
      if (is_v4) begin
         if (version != 4'h4)
            hdr_err_out = 1'b1;
         if (ihl < `IPV4_MIN_IHL)
            hdr_err_out = 1'b1;
         if (ihl_bytes != hdr_bytes_in)
            hdr_err_out = 1'b1;
      end else if (is_v6) begin
         if (version != 4'h6)
            hdr_err_out = 1'b1;
         if (hdr_bytes_in != `IPV6_HDR_BYTES)
            hdr_err_out = 1'b1;
      end
   end

endmodule

// ### sim/eth_tx_desc_ctrl_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker: control decode and frame-end plan
module eth_tx_desc_ctrl_monitor (
   // Clock and reset
   input wire clk_in,
   input wire sys_rst_in,
   // Register bus
   input wire [4:0] avs_address_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   input wire avs_waitrequest_out,
   // Descriptor fetch and decoded controls
   input wire desc_valid_in,
   input wire desc_ready_out,
   input wire [31:0] desc_word0_in,
   input wire [31:0] desc_word2_in,
   input wire ctl_ts_en_out,
   input wire [1:0] ctl_csum_mode_out,
   input wire [12:0] ctl_buf2_size_out,
   input wire [31:0] next_desc_addr_out,
   // Frame end plan
   input wire mac_frame_end_in,
   input wire [13:0] mac_frame_len_in,
   input wire mac_plan_valid_out,
   input wire [5:0] mac_pad_bytes_out,
   input wire mac_append_crc_out
);
   reg supp_crc_r;
   reg supp_pad_r;
   reg [31:0] ring_base_r;
   // Shadow of first-segment controls; only full-word base writes
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         supp_crc_r <= 1'b0;
         supp_pad_r <= 1'b0;
         ring_base_r <= 32'h0;
      end else begin
         if (desc_valid_in && desc_ready_out && desc_word0_in[28]) begin
            supp_crc_r <= desc_word0_in[27];
            supp_pad_r <= desc_word0_in[26];
         end
         if (avs_write_in && !avs_waitrequest_out &&
             avs_address_in[4:2] == 3'h1 && avs_byteenable_in == 4'hf) begin
            ring_base_r <= avs_writedata_in;
         end
      end
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   sequence s_take(b);
      desc_valid_in && desc_ready_out && b;
   endsequence
   sequence s_end(c);
      mac_frame_end_in && c;
   endsequence
   property p_crc;
      s_end(mac_frame_len_in >= 14'h3c) |=>
         mac_plan_valid_out && mac_append_crc_out == !supp_crc_r;
   endproperty
   a_crc: assert property (p_crc)
      else $error("crc plan wrong");
   property p_pad;
      s_end(mac_frame_len_in < 14'h3c && !supp_pad_r) |=>
         mac_append_crc_out &&
         mac_pad_bytes_out == 6'h3c - $past(mac_frame_len_in[5:0]);
   endproperty
   a_pad: assert property (p_pad)
      else $error("pad plan wrong");
   property p_nopad;
      s_end(supp_pad_r) |=>
         mac_pad_bytes_out == 6'h0 && mac_append_crc_out == !supp_crc_r;
   endproperty
   a_nopad: assert property (p_nopad)
      else $error("pad not suppressed");
   property p_ts;
      s_take(desc_word0_in[28]) |=> ctl_ts_en_out == $past(desc_word0_in[25]);
   endproperty
   a_ts: assert property (p_ts)
      else $error("timestamp enable wrong");
   property p_csum;
      s_take(desc_word0_in[28]) |=>
         ctl_csum_mode_out == $past(desc_word0_in[23:22]);
   endproperty
   a_csum: assert property (p_csum)
      else $error("checksum mode wrong");
   property p_keep;
      s_take(!desc_word0_in[28]) |=> $stable(ctl_csum_mode_out) &&
         $stable(ctl_ts_en_out);
   endproperty
   a_keep: assert property (p_keep)
      else $error("control changed mid frame");
   property p_ring;
      s_take(desc_word0_in[21]) |=> next_desc_addr_out == ring_base_r;
   endproperty
   a_ring: assert property (p_ring)
      else $error("ring end address wrong");
   property p_chain;
      s_take(desc_word0_in[21:20] == 2'h1) |=> ctl_buf2_size_out == 13'h0 &&
         next_desc_addr_out == $past(desc_word2_in);
   endproperty
   a_chain: assert property (p_chain)
      else $error("chained address wrong");
endmodule

bind eth_tx_desc_ctrl eth_tx_desc_ctrl_monitor mon_u (.*);

// ### sim/desc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host memory stand-in: offers queued descriptors in order
module desc_host_model (
   // Clock and reset
   input wire clk_in,
   input wire sys_rst_in,
   // Descriptor handshake
   input wire desc_ready_in,
   output wire desc_valid_out,
   output wire [31:0] desc_addr_out,
   output wire [31:0] desc_word0_out,
   output wire [31:0] desc_word1_out,
   output wire [31:0] desc_word2_out
);
   reg [127:0] pend_q[$];
   reg [127:0] offer_r = 128'h0;
   reg valid_r = 1'b0;
   reg [2:0] pace_r = 3'h0;
   assign desc_valid_out = valid_r;
   assign {desc_addr_out, desc_word0_out, desc_word1_out, desc_word2_out} =
      offer_r;
   // Queue one descriptor as {address, word0, word1, word2}
   task push(input [127:0] d);
      pend_q.push_back(d);
   endtask
   // Offer held until taken; one slow beat in four; idle lines
   // toggle so stale contents never look valid
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         valid_r <= 1'b0;
         pace_r <= 3'h0;
      end else begin
         pace_r <= pace_r + 3'h1;
         if (valid_r && !desc_ready_in) begin
            valid_r <= 1'b1;
         end else if (pend_q.size() > 0 && pace_r[1:0] != 2'h3) begin
            offer_r <= pend_q.pop_front();
            valid_r <= 1'b1;
         end else begin
            valid_r <= 1'b0;
            offer_r <= ~offer_r;
         end
      end
   end
endmodule

// ### sim/eth_tx_desc_ctrl_tb.sv
`timescale 1ns/1ps
module eth_tx_desc_ctrl_tb;
   // ==========================================================
   // Stimulus, observed signals and model state
   reg clk_in = 1'b0;
   reg sys_rst_in = 1'b1;
   reg [4:0] avs_address_in = 5'h0;
   reg avs_read_in = 1'b0;
   reg avs_write_in = 1'b0;
   reg [31:0] avs_writedata_in = 32'h0;
   reg [3:0] avs_byteenable_in = 4'hf;
   reg mac_frame_end_in = 1'b0;
   reg [13:0] mac_frame_len_in = 14'h0;
   reg hdr_valid_in = 1'b0;
   reg [15:0] hdr_eth_type_in = 16'h0;
   reg [7:0] hdr_ver_ihl_in = 8'h0;
   reg [7:0] hdr_bytes_in = 8'h0;
   reg ts_valid_in = 1'b0;
   reg [63:0] ts_value_in = 64'h0;
   reg mac_tx_done_in = 1'b0;
   wire avs_waitrequest_out, irq_out, desc_valid_in, desc_ready_out;
   wire ctl_valid_out, ctl_first_out, ctl_last_out, ctl_ts_en_out;
   wire mac_plan_valid_out, mac_append_crc_out, wb_valid_out;
   wire [1:0] ctl_csum_mode_out;
   wire [5:0] mac_pad_bytes_out;
   wire [12:0] ctl_buf1_size_out, ctl_buf2_size_out;
   wire [31:0] avs_readdata_out, desc_addr_in, desc_word0_in, desc_word1_in;
   wire [31:0] desc_word2_in, next_desc_addr_out, wb_addr_out, wb_word0_out;
   wire [31:0] wb_word2_out, wb_word3_out;
   integer err_count = 0;
   integer checks_done = 0;
   integer m;
   reg [31:0] rng_r = 32'he855;
   reg [31:0] ring_r;
   reg [31:0] rd_r;
   reg [5:0] lat_r = 6'h0;
   reg [3:0] sts_r = 4'h0;
   reg [3:0] mask_r = 4'h0;
   reg [127:0] wb_r;
   reg [62:0] exp_ctl[$];
   reg [6:0] exp_plan[$];
   reg [127:0] exp_wb[$];
   wire [62:0] ctl_w = {ctl_first_out, ctl_last_out, ctl_ts_en_out,
      ctl_csum_mode_out, ctl_buf1_size_out, ctl_buf2_size_out,
      next_desc_addr_out};
   wire [127:0] wb_w = {wb_addr_out, wb_word0_out, wb_word2_out, wb_word3_out};

   eth_tx_desc_ctrl dut_u (.*);
   desc_host_model host_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .desc_ready_in(desc_ready_out), .desc_valid_out(desc_valid_in),
      .desc_addr_out(desc_addr_in), .desc_word0_out(desc_word0_in),
      .desc_word1_out(desc_word1_in), .desc_word2_out(desc_word2_in));

   always #50 clk_in = ~clk_in;

   // ==========================================================
   // Helpers
   function [31:0] rnd();
      rng_r = rng_r ^ (rng_r << 13);
      rng_r = rng_r ^ (rng_r >> 17);
      rng_r = rng_r ^ (rng_r << 5);
      rnd = rng_r;
   endfunction
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk_out(input [127:0] got, input [127:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("[ERR] %0t port result %h want %h", $time, got, exp);
      end
   endtask
   task chk_bus(input [31:0] got, input [31:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("[ERR] %0t register read %h want %h", $time, got, exp);
      end
   endtask
   task stuck;
      err_count = err_count + 1;
      $display("[ERR] %0t wait ran out", $time);
      end_of_test;
   endtask
   // Request held until waitrequest is seen low at an edge
   task bus(input [4:0] a, input rd, input [31:0] d);
      integer k;
      @(posedge clk_in);
      avs_address_in <= a;
      avs_read_in <= rd;
      avs_write_in <= !rd;
      avs_writedata_in <= d;
      @(posedge clk_in);
      for (k = 0; avs_waitrequest_out !== 1'b0; k = k + 1) begin
         if (k == 50)
            stuck;
         @(posedge clk_in);
      end
      rd_r = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task bus_rd(input [4:0] a, input [31:0] exp);
      bus(a, 1'b1, 32'h0);
      chk_bus(rd_r, exp);
   endtask
   task drain;
      integer k;
      for (k = 0; exp_ctl.size() + exp_plan.size() + exp_wb.size() > 0;
           k = k + 1) begin
         if (k == 300)
            stuck;
         @(posedge clk_in);
      end
   endtask
   // Model of one descriptor take, then hand it to the host side
   task send(input [31:0] w0);
      reg [31:0] a;
      reg [31:0] w1;
      reg [31:0] w2;
      a = rnd() & 32'hffff_fff0;
      w1 = rnd();
      w2 = rnd();
      if (w0[28])
         lat_r = w0[27:22];
      if (w0[21])
         sts_r[2] = 1'b1;
      if (w0[29])
         wb_r = {a, w0, 64'h0};
      exp_ctl.push_back({w0[28], w0[29], lat_r[3], lat_r[1:0], w1[12:0],
         ((w0[21:20] == 2'h1) ? 13'h0 : w1[28:16]),
         (w0[21] ? ring_r : (w0[20] ? w2 : a + 32'h10))});
      host_u.push({a, w0, w1, w2});
   endtask
   // One frame: segments, end plan, header, timestamp, write-back
   task frame(input integer n, input [31:0] f, input [13:0] len,
              input [31:0] h, input ts);
      integer i;
      reg [63:0] tv;
      reg he;
      reg cap;
      reg padit;
      for (i = 0; i < n; i = i + 1)
         send(((i == 0) ? (f | 32'h1000_0000) : (rnd() & 32'h0ff0_0000)) |
              ((i == n - 1) ? 32'h2000_0000 : 32'h0));
      drain;
      tv = {rnd(), rnd()};
      he = (h[31:16] == 16'h0800) ? (h[15:12] != 4'h4 || h[11:8] < 4'h5 ||
           {h[11:8], 2'h0} != h[7:0]) : ((h[31:16] == 16'h86dd) &&
           (h[15:12] != 4'h6 || h[7:0] != 8'h28));
      cap = ts & lat_r[3];
      padit = len < 14'h3c && !lat_r[4];
      exp_plan.push_back({(padit ? 6'h3c - len[5:0] : 6'h0),
         padit | !lat_r[5]});
      exp_wb.push_back({wb_r[127:82], cap, he, wb_r[79:64],
         (cap ? {tv[31:0], tv[63:32]} : 64'h0)});
      sts_r = sts_r | {1'b1, 1'b0, he, cap};
      @(posedge clk_in);
      {hdr_eth_type_in, hdr_ver_ihl_in, hdr_bytes_in} <= h;
      hdr_valid_in <= 1'b1;
      ts_value_in <= tv;
      ts_valid_in <= ts;
      mac_frame_len_in <= len;
      mac_frame_end_in <= 1'b1;
      @(posedge clk_in);
      hdr_valid_in <= 1'b0;
      ts_valid_in <= 1'b0;
      mac_frame_end_in <= 1'b0;
      mac_tx_done_in <= 1'b1;
      @(posedge clk_in);
      mac_tx_done_in <= 1'b0;
      drain;
      repeat (2) @(posedge clk_in);
      chk_out(irq_out, |(sts_r & mask_r));
      bus_rd(5'h10, {24'h0, he, cap, lat_r[1:0], lat_r[3], lat_r[4],
         lat_r[5], 1'b0});
      bus_rd(5'h08, {28'h0, sts_r});
      sts_r = 4'h0;
      repeat (2) @(posedge clk_in);
      chk_out(irq_out, 1'b0);
   endtask

   // Results matched against the model in order of arrival
   always @(posedge clk_in) begin
      if (ctl_valid_out === 1'b1)
         chk_out(ctl_w, exp_ctl.pop_front());
      if (mac_plan_valid_out === 1'b1)
         chk_out({mac_pad_bytes_out, mac_append_crc_out},
            exp_plan.pop_front());
      if (wb_valid_out === 1'b1)
         chk_out(wb_w, exp_wb.pop_front());
   end

   // ==========================================================
   // Main sequence; header cases cycle through good and bad kinds
   initial begin : main_seq
      reg [31:0] hdr_t [0:5];
      hdr_t[0] = 32'h0800_4514;
      hdr_t[1] = 32'h0800_4410;
      hdr_t[2] = 32'h86dd_6028;
      hdr_t[3] = 32'h86dd_6020;
      hdr_t[4] = 32'h86dd_4514;
      hdr_t[5] = 32'h0800_4614;
      repeat (12) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      bus_rd(5'h00, 32'h0);
      bus_rd(5'h04, 32'h0);
      bus_rd(5'h0c, 32'h0);
      bus_rd(5'h1c, 32'h0);
      ring_r = rnd() & 32'hffff_fff0;
      bus(5'h04, 1'b0, ring_r);
      bus_rd(5'h04, ring_r);
      bus(5'h00, 1'b0, 32'h1);
      for (m = 0; m < 12; m = m + 1) begin
         if (m == 6) begin
            mask_r = 4'hf;
            bus(5'h0c, 1'b0, 32'hf);
         end
         frame(1 + rnd() % 3, (rnd() & 32'h0e30_0000) | {8'h0, m[1:0], 22'h0},
            14'((m < 2) ? 59 + m : rnd() % 80), hdr_t[m % 6],
            rnd() > 32'h8000_0000);
      end
      bus_rd(5'h14, 32'hc);
      end_of_test;
   end
endmodule
